// File: sbtc_defs.vh
// constants and register map for the sixteen-bit timer/counter
// Operation
// - count only while counter_run is one; hold count when zero.
// - wide_access_mode one gives buffered 16-bit access; zero gives two byte accesses.
// - osc_clock_status is read-only, one while system clock comes from this oscillator.
// - input_divider_select codes 11,10,01,00 divide count input by 8,4,2,1.
// - low_power_osc_enable starts oscillator; zero shuts inverter and feedback resistor off.
// - external source: ext_sync_bypass one counts unsynchronised, zero synchronised; else ignored.
// - source select zero counts every fourth system clock; one counts external rising edges.
// - while counting, oscillator pins are forced to inputs and read as zero.
// - wide mode: low byte read copies live high byte into high buffer.
// - wide mode: low byte write loads live high byte from buffer simultaneously.
// - high buffer write keeps prescaler; any low byte write clears prescaler.
// - enabled oscillator keeps running in all power-managed modes.
// - count wraps FFFF to 0000, setting overflow flag; enabled flag raises interrupt.
// - compare trigger clears count in timer or sync counter mode; write wins.
`ifndef SBTC_DEFS_VH
`define SBTC_DEFS_VH
`define SBTC_ADDR_CTRL 4'h0
`define SBTC_ADDR_LOW 4'h4
`define SBTC_ADDR_HIGH 4'h8
`define SBTC_ADDR_STAT 4'hc
`define SBTC_ADDR_CLR 5'h10
`define SBTC_ADDR_IEN 5'h14
`define SBTC_CTRL_RST 8'h00
`define SBTC_B_RUN 0
`define SBTC_B_SRC 1
`define SBTC_B_BYP 2
`define SBTC_B_OSC 3
`define SBTC_B_DIV_LO 4
`define SBTC_B_STAT 6
`define SBTC_B_WIDE 7
`define SBTC_INSTR_DIV 2'h3
`define SBTC_RESP_OK 2'h0
`define SBTC_RESP_SLVERR 2'h2
`endif

// File: sbtc_sync3.v
// three-stage synchroniser with agreement filter for one pin
module sbtc_sync3 (
  // clock and reset
  input wire clk_sys_i,
  input wire nrst_i,
  // pin and filtered level
  input wire pin_i,
  output reg level_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  // first stage read only by second
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule

// File: sbtc_timer.v
// sixteen-bit timer/counter with axi4-lite register access
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`include "sbtc_defs.vh"
module sbtc_timer (
  // clock and reset
  input wire clk_sys_i,
  input wire nrst_i,
  // axi4-lite write address and data
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // count sources and system hooks
  input wire ext_count_pin_i,
  input wire osc_in_pin_i,
  input wire sys_clk_from_osc_i,
  input wire compare_trigger_i,
  // oscillator and pin control
  output wire osc_amp_enable_o,
  output wire osc_pins_as_input_o,
  output wire [1:0] osc_pin_read_o,
  // interrupt
  output wire irq_o
);
  reg [7:0] ctrl_reg;
  reg [15:0] count_reg;
  reg [15:0] count_next;
  reg [7:0] high_buffer_reg;
  reg [2:0] presc_reg;
  reg [2:0] presc_next;
  reg [1:0] instr_div_reg;
  reg ext_prev_reg;
  reg overflow_flag_reg;
  reg overflow_irq_enable_reg;
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [4:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire ext_sync;
  wire counter_run;
  wire count_source_select;
  wire ext_sync_bypass;
  wire low_power_osc_enable;
  wire wide_access_mode;
  wire [1:0] input_divider_select;
  wire ext_raw;
  wire ext_level;
  wire ext_rise;
  wire tick;
  reg presc_done;
  wire wr_fire;
  wire rd_fire;
  wire wr_low;
  wire wr_high;
  wire rd_low;
  wire wr_lane0;
  wire wrap;
  wire trig_clear;

  assign counter_run = ctrl_reg[`SBTC_B_RUN];
  assign count_source_select = ctrl_reg[`SBTC_B_SRC];
  assign ext_sync_bypass = ctrl_reg[`SBTC_B_BYP];
  assign low_power_osc_enable = ctrl_reg[`SBTC_B_OSC];
  assign input_divider_select = ctrl_reg[`SBTC_B_DIV_LO+1:`SBTC_B_DIV_LO];
  assign wide_access_mode = ctrl_reg[`SBTC_B_WIDE];

  // oscillator amplifier runs whenever enabled; it has no power-mode input
  assign osc_amp_enable_o = low_power_osc_enable;
  // pins forced to input while counting and read as zero
  assign osc_pins_as_input_o = counter_run;
  assign osc_pin_read_o = 2'h0;

  // external source: oscillator when enabled, else the count pin
  assign ext_raw = low_power_osc_enable ? osc_in_pin_i : ext_count_pin_i;

  sbtc_sync3 u_ext_sync (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .pin_i(ext_raw),
    .level_o(ext_sync)
  );

  // bypass still sampled once: a flop clock domain cannot count truly async
  assign ext_level = ext_sync_bypass ? ext_raw : ext_sync;
  assign ext_rise = ext_level & ~ext_prev_reg;
  // internal tick each fourth system clock
  assign tick = count_source_select ? ext_rise : (instr_div_reg == `SBTC_INSTR_DIV);

  // prescale terminal count per divider code
  always @* begin
    case (input_divider_select)
      2'h0: presc_done = 1'b1;
      2'h1: presc_done = (presc_reg[0] == 1'b1);
      2'h2: presc_done = (presc_reg[1:0] == 2'h3);
      2'h3: presc_done = (presc_reg == 3'h7);
      default: presc_done = 1'b1;
    endcase
  end

  // bus handshake: address and data accepted independently
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_hold_reg & w_hold_reg;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign wr_lane0 = wr_fire & w_strb_reg[0];
  assign wr_low = wr_lane0 & (aw_addr_reg[4:2] == `SBTC_ADDR_LOW >> 2);
  assign wr_high = wr_lane0 & (aw_addr_reg[4:2] == `SBTC_ADDR_HIGH >> 2);
  assign rd_low = rd_fire & (s_axi_araddr[4:2] == `SBTC_ADDR_LOW >> 2);
  assign wrap = counter_run & tick & presc_done & (count_reg == 16'hffff);
  // reset trigger only meaningful in timer or synchronised counter modes
  assign trig_clear = compare_trigger_i & (~count_source_select | ~ext_sync_bypass);

  // next count and prescaler
  always @* begin
    count_next = count_reg;
    presc_next = presc_reg;
    if (counter_run && tick) begin
      if (presc_done) begin
        presc_next = 3'h0;
        count_next = count_reg + 16'h0001;
      end else begin
        presc_next = presc_reg + 3'h1;
      end
    end
    if (trig_clear) begin
      count_next = 16'h0000;
    end
    // software write beats the compare trigger
    if (wr_low) begin
      presc_next = 3'h0;
      if (wide_access_mode) begin
        count_next = {high_buffer_reg, w_data_reg[7:0]};
      end else begin
        count_next = {count_next[15:8], w_data_reg[7:0]};
      end
    end else if (wr_high && !wide_access_mode) begin
      count_next = {w_data_reg[7:0], count_next[7:0]};
    end
  end

  // counter state
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= 16'h0000;
      presc_reg <= 3'h0;
      instr_div_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      presc_reg <= presc_next;
      instr_div_reg <= instr_div_reg + 2'h1;
      ext_prev_reg <= ext_level;
    end
  end

  // registers, high buffer and overflow status
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= `SBTC_CTRL_RST;
      high_buffer_reg <= 8'h00;
      overflow_flag_reg <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
    end else begin
      if (wr_lane0 && aw_addr_reg == `SBTC_ADDR_CTRL) begin
        // status bit is not writable
        ctrl_reg <= {w_data_reg[7], 1'b0, w_data_reg[5:0]};
      end
      if (wr_high && wide_access_mode) begin
        high_buffer_reg <= w_data_reg[7:0];
      end else if (rd_low && wide_access_mode) begin
        high_buffer_reg <= count_reg[15:8];
      end
      if (wr_lane0 && aw_addr_reg == `SBTC_ADDR_IEN) begin
        overflow_irq_enable_reg <= w_data_reg[0];
      end
      // set wins over a coinciding clear
      if (wrap) begin
        overflow_flag_reg <= 1'b1;
      end else if (wr_lane0 && aw_addr_reg == `SBTC_ADDR_CLR && w_data_reg[0]) begin
        overflow_flag_reg <= 1'b0;
      end
    end
  end

  assign irq_o = overflow_flag_reg & overflow_irq_enable_reg;

  // write channel capture and response
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 5'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBTC_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg[1:0] != 2'h0 || aw_addr_reg > `SBTC_ADDR_IEN) ?
          `SBTC_RESP_SLVERR : `SBTC_RESP_OK;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data path; status bit reflects the system clock source live
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SBTC_RESP_OK;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SBTC_RESP_OK;
      case (s_axi_araddr)
        `SBTC_ADDR_CTRL: s_axi_rdata <= {24'h0, ctrl_reg[7], sys_clk_from_osc_i,
                                         ctrl_reg[5:0]};
        `SBTC_ADDR_LOW: s_axi_rdata <= {24'h0, count_reg[7:0]};
        `SBTC_ADDR_HIGH: s_axi_rdata <= {24'h0, wide_access_mode ? high_buffer_reg :
                                         count_reg[15:8]};
        `SBTC_ADDR_STAT: s_axi_rdata <= {31'h0, overflow_flag_reg};
        `SBTC_ADDR_CLR: s_axi_rdata <= 32'h00000000;
        `SBTC_ADDR_IEN: s_axi_rdata <= {31'h0, overflow_irq_enable_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SBTC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: sbtc_timer_checker.sv
// bus handshake and pin assertions for the timer/counter
module sbtc_timer_checker (
  // clock and reset
  input wire clk_sys_i,
  input wire nrst_i,
  // bus handshake
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  // oscillator pins
  input wire osc_amp_enable_o,
  input wire osc_pins_as_input_o,
  input wire [1:0] osc_pin_read_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  pin_read_zero_a: assert property (osc_pin_read_o == 2'h0)
    else $error("oscillator pins do not read zero");
  amp_by_write_a: assert property ($changed(osc_amp_enable_o) |-> $rose(s_axi_bvalid))
    else $error("oscillator enable moved without a write");
  pins_by_write_a: assert property ($changed(osc_pins_as_input_o) |-> $rose(s_axi_bvalid))
    else $error("pin direction moved without a write");
  write_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  read_resp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped or changed");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answering");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while answering");
  read_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without a request");
  read_error_a: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr > 5'h14)
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule

// File: sbtc_src_model.sv
// count source model: external pin and crystal, both idle low between bursts
module sbtc_src_model (
  input wire clk_sys_i,
  output logic ext_count_pin_o,
  output logic osc_in_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ext_count_pin_o = 1'h0;
    osc_in_pin_o = 1'h0;
  end
  // n rising edges, each level held half cycles; slow against the system clock
  task burst(input bit osc, input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge clk_sys_i);
      if (osc) osc_in_pin_o <= 1'h1; else ext_count_pin_o <= 1'h1;
      repeat (half) @(posedge clk_sys_i);
      if (osc) osc_in_pin_o <= 1'h0; else ext_count_pin_o <= 1'h0;
    end
  endtask
endmodule

// File: sixteen_bit_timer_counter_bench.sv
// self-checking bench for the timer/counter
module sixteen_bit_timer_counter_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'h0, nrst_i = 1'h0, sys_clk_from_osc_i = 1'h0, compare_trigger_i = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, lag = 1'h0;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, u;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp, osc_pin_read_o, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ext_count_pin_i, osc_in_pin_i, osc_amp_enable_o, osc_pins_as_input_o, irq_o;
  logic [15:0] seed = 16'hd57e;
  int n_mismatch = 0, n_checks = 0, cyc = 0, k;
  sbtc_timer DUT (.*);
  sbtc_src_model SRC (.clk_sys_i(clk_sys_i), .ext_count_pin_o(ext_count_pin_i),
    .osc_in_pin_o(osc_in_pin_i));
  always #50 clk_sys_i = ~clk_sys_i;
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // lag raises bready late so the slave must hold its answer
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= ~lag;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    if (lag) begin
      s_axi_bready <= 1'h1;
      @(posedge clk_sys_i);
    end
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] p);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= ~lag;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    if (lag) begin
      s_axi_rready <= 1'h1;
      @(posedge clk_sys_i);
    end
    d = s_axi_rdata;
    p = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, far above the fewer than two thousand cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'h1;
    rd(5'h00, v, r); chk("ctrl_reset", v, 32'h0);
    sys_clk_from_osc_i <= 1'h1;
    wr(5'h00, 32'hff); chk("ok_wresp", s_axi_bresp, 32'h0);
    rd(5'h00, v, r); chk("ctrl_all", v, 32'hff);
    chk("osc_amp", osc_amp_enable_o, 32'h1);
    chk("pins_in", osc_pins_as_input_o, 32'h1);
    sys_clk_from_osc_i <= 1'h0;
    wr(5'h00, 32'h40); rd(5'h00, v, r); chk("ctrl_ro", v, 32'h0);
    chk("pins_free", osc_pins_as_input_o, 32'h0);
    rd(5'h18, v, r); chk("bad_resp", r, 32'h2);
    wr(5'h18, 32'h0); chk("bad_wresp", s_axi_bresp, 32'h2);
    // internal count, every divider code; low write also clears the prescaler
    for (k = 0; k < 4; k++) begin
      wr(5'h08, 32'h0); wr(5'h04, 32'h0);
      wr(5'h00, k * 16 + 1);
      repeat (64 << k) @(posedge clk_sys_i);
      wr(5'h00, 32'h0); rd(5'h04, v, r);
      chk("div_count", v >= 14 && v <= 18, 32'h1);
      // stopped counter must not move
      u = v;
      repeat (20) @(posedge clk_sys_i);
      rd(5'h04, v, r);
      chk("hold_stop", v, u);
      chk("low_resp", r, 32'h0);
    end
    // external pin synced, unsynced, then crystal after its start-up wait
    for (k = 0; k < 3; k++) begin
      wr(5'h08, 32'h0); wr(5'h04, 32'h0);
      wr(5'h00, k == 2 ? 32'h0b : 32'h03 | k << 2);
      if (k == 2) repeat (50) @(posedge clk_sys_i);
      SRC.burst(k == 2, 5 + k, 4);
      repeat (8) @(posedge clk_sys_i);
      wr(5'h00, 32'h0); rd(5'h04, v, r); chk("ext_count", v, 5 + k);
    end
    // wide access against byte access, random bytes
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      lag = seed[3];
      wr(5'h00, 32'h0); wr(5'h08, {24'h0, seed[15:8]});
      wr(5'h00, 32'h80); rd(5'h04, v, r); rd(5'h08, v, r);
      chk("wide_rd", v, {24'h0, seed[15:8]});
      wr(5'h08, {24'h0, ~seed[15:8]}); wr(5'h04, {24'h0, seed[7:0]});
      wr(5'h00, 32'h0); rd(5'h08, v, r); chk("wide_hi", v, {24'h0, ~seed[15:8]});
      rd(5'h04, v, r); chk("wide_lo", v, {24'h0, seed[7:0]});
    end
    // wrap, flag, interrupt mask and clear
    wr(5'h14, 32'h1); wr(5'h08, 32'hff); wr(5'h04, 32'hf8); wr(5'h00, 32'h1);
    repeat (60) @(posedge clk_sys_i);
    wr(5'h00, 32'h0); rd(5'h0c, v, r); chk("ovf_flag", v, 32'h1);
    chk("irq_on", irq_o, 32'h1);
    rd(5'h08, v, r); chk("wrap_hi", v, 32'h0);
    wr(5'h14, 32'h0); chk("irq_mask", irq_o, 32'h0);
    wr(5'h14, 32'h1); wr(5'h10, 32'h1); rd(5'h0c, v, r); chk("ovf_clr", v, 32'h0);
    chk("irq_off", irq_o, 32'h0);
    // compare trigger clears the count in timer mode
    wr(5'h04, 32'h55);
    @(posedge clk_sys_i) compare_trigger_i <= 1'h1;
    @(posedge clk_sys_i) compare_trigger_i <= 1'h0;
    rd(5'h04, v, r); chk("trig_clr", v, 32'h0);
    wrap_up;
  end
endmodule
bind sbtc_timer sbtc_timer_checker CHK (.*);
